// ===== verilog/cbs_pkg.sv
// Purpose: shared types and constants for the bus-cycle sequencer
// Assumes: 16-bit bus words, 32-bit addresses
// Notes: one bus cycle per accepted request
package cbs_pkg;
  localparam int unsigned CBS_AW = 32;
  localparam int unsigned CBS_DW = 16;
  localparam logic [31:0] CBS_WORD_STEP = 32'h0000_0002;
  localparam logic [31:0] CBS_BYTE_STEP = 32'h0000_0001;
  localparam logic [31:0] CBS_PUSH_STEP = 32'h0000_0004;
  localparam logic [31:0] CBS_RESET_VEC = 32'h0000_0000;
  localparam logic [2:0] CBS_PUSH_MIN = 3'h2;
  localparam logic [2:0] CBS_PUSH_MAX = 3'h4;

  typedef enum logic [2:0] {
    CBS_OP_RESET = 3'h0,
    CBS_OP_IRQ = 3'h1,
    CBS_OP_CTRL_STORE = 3'h2,
    CBS_OP_PUSH = 3'h3,
    CBS_OP_MOVE = 3'h4,
    CBS_OP_TAS = 3'h5
  } cbs_op_e;

  typedef struct packed {
    cbs_op_e op;
    logic [31:0] addr;
    logic [31:0] pc;
    logic [31:0] src;
    logic [31:0] dst;
    logic [15:0] count;
    logic [2:0] nregs;
    logic [15:0] wdata;
    logic [15:0] wdata2;
    logic [7:0] extended_control_reg;
    logic wake;
  } cbs_cmd_s;

  typedef struct packed {
    logic valid;
    logic write;
    logic byte_en;
    logic lock;
    logic [31:0] addr;
    logic [15:0] wdata;
  } cbs_bus_s;
endpackage

// ===== verilog/cbs_bus_port.sv
// Purpose: holds one bus request until the memory accepts it
// Assumes: memory answers with a one-cycle done pulse
// Notes: done may arrive at the earliest one cycle after issue
`timescale 1ns/1ps
module cbs_bus_port
  import cbs_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic issue_i,
  input wire cbs_bus_s req_i,
  input wire logic done_i,
  input wire logic [15:0] rdata_i,
  output logic busy_o,
  output logic finish_o,
  output logic [15:0] rdata_o,
  output cbs_bus_s bus_o
);
  cbs_bus_s bus_r, bus_nxt;
  logic fin_r, fin_nxt;
  logic [15:0] rd_r, rd_nxt;

  always_comb begin
    bus_nxt = bus_r;
    fin_nxt = 1'b0;
    rd_nxt = rd_r;
    if (bus_r.valid && done_i) begin
      bus_nxt.valid = 1'b0;
      bus_nxt.lock = 1'b0;
      fin_nxt = 1'b1;
      rd_nxt = rdata_i;
    end else if (!bus_r.valid && issue_i) begin
      bus_nxt = req_i;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      bus_r <= '0;
      fin_r <= 1'b0;
      rd_r <= '0;
    end else begin
      bus_r <= bus_nxt;
      fin_r <= fin_nxt;
      rd_r <= rd_nxt;
    end
  end

  assign busy_o = bus_r.valid | fin_r;
  assign finish_o = fin_r;
  assign rdata_o = rd_r;
  assign bus_o = bus_r;
endmodule

// ===== verilog/cbs_sequencer.sv
// Purpose: orders bus cycles of exception entry and multi-cycle stores
// Assumes: decoder holds cmd_i steady while start_i is high
// Notes: a lock flag on a cycle keeps the bus through the next cycle
// Notes on behaviour
// - interrupt entry writes pc low, pc high, control byte, locked vector read, vector plus two.
// - reset reads vector, vector plus two, idles one state, fetches the start address.
// - the first prefetch after exception entry uses pushed pc plus two.
// - when waking from low power that prefetch is an internal state only.
// - the block move reads at the source and writes at the destination, both plus one per byte.
// - the block move takes its count from the count input and skips all transfers at zero.
// - a multi-register push repeats its write pair once per named register, two to four.
// - each pushed register gets one internal state, a locked high write, then a low write.
// - a control store fetches word two, prefetches, idles one state, then writes once.
`timescale 1ns/1ps
module cbs_sequencer
  import cbs_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire cbs_cmd_s cmd_i,
  input wire logic mem_done_i,
  input wire logic [15:0] mem_rdata_i,
  output cbs_bus_s mem_o,
  output logic busy_o,
  output logic done_o,
  output logic [31:0] start_addr_o,
  output logic [31:0] src_addr_reg_o,
  output logic [31:0] dst_addr_reg_o
);
  // -------------------------------------------------------------
  // states
  // -------------------------------------------------------------
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_ISSUE = 8'h02,
    ST_WAIT = 8'h04,
    ST_INT = 8'h08,
    ST_DONE = 8'h10
  } cbs_state_e;

  cbs_state_e st_r, st_nxt;
  cbs_cmd_s cmd_r, cmd_nxt;
  logic [3:0] step_r, step_nxt;
  logic [2:0] reg_r, reg_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [15:0] vhi_r, vhi_nxt;
  logic [31:0] sa_r, sa_nxt;
  logic [15:0] mvb_r, mvb_nxt;
  logic done_r, done_nxt;
  logic issue;
  cbs_bus_s req;
  logic port_busy, port_fin;
  logic [15:0] port_rd;

  function automatic cbs_bus_s mk(input logic wr, input logic bt,
                                  input logic lk, input logic [31:0] a,
                                  input logic [15:0] d);
    mk.valid = 1'b1;
    mk.write = wr;
    mk.byte_en = bt;
    mk.lock = lk;
    mk.addr = a;
    mk.wdata = d;
  endfunction

  // -------------------------------------------------------------
  // step decode: one bus cycle or internal state per step
  // -------------------------------------------------------------
  logic is_int;
  logic last;
  always_comb begin
    req = '0;
    is_int = 1'b0;
    last = 1'b0;
    unique case (cmd_r.op)
      CBS_OP_RESET: begin
        unique case (step_r)
          4'h0: req = mk(1'b0, 1'b0, 1'b0, cmd_r.addr, '0);
          4'h1: req = mk(1'b0, 1'b0, 1'b0,
                         cmd_r.addr + CBS_WORD_STEP, '0);
          4'h2: is_int = 1'b1;
          default: begin
            req = mk(1'b0, 1'b0, 1'b0, sa_r, '0);
            last = 1'b1;
          end
        endcase
      end
      CBS_OP_IRQ: begin
        unique case (step_r)
          4'h0: begin
            req = mk(1'b0, 1'b0, 1'b0, cmd_r.pc + CBS_WORD_STEP,
                     '0);
            is_int = cmd_r.wake;
          end
          4'h1: is_int = 1'b1;
          4'h2: req = mk(1'b1, 1'b0, 1'b0, cmd_r.addr - CBS_WORD_STEP,
                         cmd_r.pc[15:0]);
          4'h3: req = mk(1'b1, 1'b0, 1'b0, cmd_r.addr - CBS_PUSH_STEP,
                         cmd_r.pc[31:16]);
          4'h4: req = mk(1'b1, 1'b0, 1'b0,
                         cmd_r.addr - CBS_PUSH_STEP - CBS_WORD_STEP,
                         {cmd_r.extended_control_reg, cmd_r.extended_control_reg});
          4'h5: req = mk(1'b0, 1'b0, 1'b1, cmd_r.dst, '0);
          4'h6: req = mk(1'b0, 1'b0, 1'b0,
                         cmd_r.dst + CBS_WORD_STEP, '0);
          4'h7: is_int = 1'b1;
          default: begin
            req = mk(1'b0, 1'b0, 1'b0, sa_r, '0);
            last = 1'b1;
          end
        endcase
      end
      CBS_OP_CTRL_STORE: begin
        unique case (step_r)
          4'h0: req = mk(1'b0, 1'b0, 1'b0,
                         cmd_r.pc + CBS_WORD_STEP, '0);
          4'h1: req = mk(1'b0, 1'b0, 1'b0,
                         cmd_r.pc + CBS_PUSH_STEP, '0);
          4'h2: is_int = 1'b1;
          default: begin
            req = mk(1'b1, 1'b0, 1'b0, cmd_r.addr - CBS_WORD_STEP,
                     cmd_r.wdata);
            last = 1'b1;
          end
        endcase
      end
      CBS_OP_PUSH: begin
        unique case (step_r)
          4'h0: is_int = 1'b1;
          4'h1: req = mk(1'b1, 1'b0, 1'b1, cmd_r.addr - CBS_PUSH_STEP,
                         cmd_r.wdata2);
          default: begin
            req = mk(1'b1, 1'b0, 1'b0,
                     cmd_r.addr - CBS_PUSH_STEP + CBS_WORD_STEP,
                     cmd_r.wdata);
            last = (reg_r == 3'h1);
          end
        endcase
      end
      CBS_OP_MOVE: begin
        if (cnt_r == '0) begin
          is_int = 1'b1;
          last = 1'b1;
        end else if (step_r == 4'h0) begin
          req = mk(1'b0, 1'b1, 1'b0, cmd_r.src, '0);
        end else begin
          req = mk(1'b1, 1'b1, 1'b0, cmd_r.dst, mvb_r);
          last = (cnt_r == 16'h1);
        end
      end
      default: begin
        if (step_r == 4'h0) begin
          req = mk(1'b0, 1'b1, 1'b1, cmd_r.addr, '0);
        end else begin
          req = mk(1'b1, 1'b1, 1'b0, cmd_r.addr,
                   {8'h00, mvb_r[7:0] | 8'h80});
          last = 1'b1;
        end
      end
    endcase
  end

  // -------------------------------------------------------------
  // sequencing
  // -------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    cmd_nxt = cmd_r;
    step_nxt = step_r;
    reg_nxt = reg_r;
    cnt_nxt = cnt_r;
    vhi_nxt = vhi_r;
    sa_nxt = sa_r;
    mvb_nxt = mvb_r;
    done_nxt = 1'b0;
    issue = 1'b0;
    unique case (st_r)
      ST_IDLE: begin
        if (start_i) begin
          cmd_nxt = cmd_i;
          step_nxt = '0;
          reg_nxt = cmd_i.nregs;
          cnt_nxt = cmd_i.count;
          st_nxt = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        if (is_int) begin
          st_nxt = ST_INT;
        end else if (!port_busy) begin
          issue = 1'b1;
          st_nxt = ST_WAIT;
        end
      end
      ST_WAIT, ST_INT: begin
        if (st_r == ST_INT || port_fin) begin
          if (cmd_r.op == CBS_OP_MOVE && st_r == ST_WAIT) begin
            if (step_r == 4'h0) begin
              mvb_nxt = port_rd;
              cmd_nxt.src = cmd_r.src + CBS_BYTE_STEP;
            end else begin
              cmd_nxt.dst = cmd_r.dst + CBS_BYTE_STEP;
              cnt_nxt = cnt_r - 16'h1;
            end
          end
          if (cmd_r.op == CBS_OP_TAS && step_r == 4'h0) begin
            mvb_nxt = port_rd;
          end
          if ((cmd_r.op == CBS_OP_RESET && step_r == 4'h0)
              || (cmd_r.op == CBS_OP_IRQ && step_r == 4'h5)) begin
            vhi_nxt = port_rd;
          end
          if ((cmd_r.op == CBS_OP_RESET && step_r == 4'h1)
              || (cmd_r.op == CBS_OP_IRQ && step_r == 4'h6)) begin
            sa_nxt = {vhi_r, port_rd};
          end
          if (last) begin
            st_nxt = ST_DONE;
          end else begin
            st_nxt = ST_ISSUE;
            if (cmd_r.op == CBS_OP_MOVE) begin
              step_nxt = step_r ^ 4'h1;
            end else if (cmd_r.op == CBS_OP_PUSH && step_r == 4'h2) begin
              step_nxt = '0;
              reg_nxt = reg_r - 3'h1;
              cmd_nxt.addr = cmd_r.addr - CBS_PUSH_STEP;
            end else begin
              step_nxt = step_r + 4'h1;
            end
          end
        end
      end
      default: begin
        if (!port_busy) begin
          done_nxt = 1'b1;
          st_nxt = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      st_r <= ST_IDLE;
      cmd_r <= '0;
      step_r <= '0;
      reg_r <= '0;
      cnt_r <= '0;
      vhi_r <= '0;
      sa_r <= CBS_RESET_VEC;
      mvb_r <= '0;
      done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cmd_r <= cmd_nxt;
      step_r <= step_nxt;
      reg_r <= reg_nxt;
      cnt_r <= cnt_nxt;
      vhi_r <= vhi_nxt;
      sa_r <= sa_nxt;
      mvb_r <= mvb_nxt;
      done_r <= done_nxt;
    end
  end

  cbs_bus_port u_port (
    .clk_sys_i(clk_sys_i),
    .reset_n_i(reset_n_i),
    .issue_i(issue),
    .req_i(req),
    .done_i(mem_done_i),
    .rdata_i(mem_rdata_i),
    .busy_o(port_busy),
    .finish_o(port_fin),
    .rdata_o(port_rd),
    .bus_o(mem_o)
  );

  logic busy_r;
  always_ff @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= (st_nxt != ST_IDLE);
    end
  end

  assign busy_o = busy_r;
  assign done_o = done_r;
  assign start_addr_o = sa_r;
  assign src_addr_reg_o = cmd_r.src;
  assign dst_addr_reg_o = cmd_r.dst;
endmodule

// ===== test/cbs_sequencer_properties.sv
// Purpose: bus-order checks for the sequencer
// Assumes: one clock, sync active-low reset
// Notes: bound to cbs_sequencer below
`timescale 1ns/1ps
module cbs_sequencer_properties
  import cbs_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire cbs_cmd_s cmd_i,
  input wire logic mem_done_i,
  input wire cbs_bus_s mem_o,
  input wire logic busy_o,
  input wire logic done_o
);
  // ---
  // last completed address
  // ---
  logic [31:0] seen_r;
  logic [31:0] seen_nxt;
  logic take;
  logic fin;
  assign take = start_i && !busy_o;
  assign fin = mem_o.valid && mem_done_i;
  always_comb begin
    seen_nxt = seen_r;
    if (fin) begin
      seen_nxt = mem_o.addr;
    end
  end
  always_ff @(posedge clk_sys_i) begin
    seen_r <= reset_n_i ? seen_nxt : 32'h0000_0000;
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!reset_n_i);
  // ---
  // properties
  // ---
  property p_hold;
    mem_o.valid && !mem_done_i |=> mem_o.valid && $stable(mem_o.addr);
  endproperty
  a_hold: assert property (p_hold)
    else $error("request dropped early");
  property p_vec;
    fin && mem_o.lock && !mem_o.write && !mem_o.byte_en |-> ##[1:6]
      (mem_o.valid && !mem_o.write && mem_o.addr == seen_r + CBS_WORD_STEP);
  endproperty
  a_vec: assert property (p_vec)
    else $error("vector pair broken");
  property p_push;
    fin && mem_o.lock && mem_o.write |-> ##[1:6]
      (mem_o.valid && mem_o.write && mem_o.addr == seen_r + CBS_WORD_STEP);
  endproperty
  a_push: assert property (p_push)
    else $error("push pair broken");
  property p_tas;
    fin && mem_o.lock && !mem_o.write && mem_o.byte_en |-> ##[1:6]
      (mem_o.valid && mem_o.write && mem_o.byte_en && mem_o.addr == seen_r);
  endproperty
  a_tas: assert property (p_tas)
    else $error("locked byte pair broken");
  property p_reset;
    take && cmd_i.op == CBS_OP_RESET |-> ##2
      (mem_o.valid && !mem_o.write && mem_o.addr == $past(cmd_i.addr, 2));
  endproperty
  a_reset: assert property (p_reset)
    else $error("vector read missing");
  property p_pref;
    take && cmd_i.op == CBS_OP_IRQ && !cmd_i.wake |-> ##2 (mem_o.valid &&
      mem_o.addr == $past(cmd_i.pc, 2) + CBS_WORD_STEP);
  endproperty
  a_pref: assert property (p_pref)
    else $error("prefetch address wrong");
  property p_wake;
    take && cmd_i.op == CBS_OP_IRQ && cmd_i.wake |=> (!mem_o.valid)[*3];
  endproperty
  a_wake: assert property (p_wake)
    else $error("bus used on wake");
  property p_ctrl;
    take && cmd_i.op == CBS_OP_CTRL_STORE |-> ##2 (mem_o.valid &&
      !mem_o.write && mem_o.addr == $past(cmd_i.pc, 2) + CBS_WORD_STEP);
  endproperty
  a_ctrl: assert property (p_ctrl)
    else $error("second word fetch wrong");
  property p_move0;
    take && cmd_i.op == CBS_OP_MOVE && cmd_i.count == 16'h0000 |=>
      (!mem_o.valid throughout (##[0:12] done_o));
  endproperty
  a_move0: assert property (p_move0)
    else $error("empty move used bus");
  c_tas: cover property (fin && mem_o.lock && mem_o.byte_en);
  c_push: cover property (fin && mem_o.lock && mem_o.write);
  c_wake: cover property (take && cmd_i.op == CBS_OP_IRQ && cmd_i.wake);
endmodule

bind cbs_sequencer cbs_sequencer_properties u_props (
  .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .start_i(start_i),
  .cmd_i(cmd_i), .mem_done_i(mem_done_i), .mem_o(mem_o),
  .busy_o(busy_o), .done_o(done_o)
);

// ===== test/cbs_mem_model.sv
// Purpose: memory answering sequencer bus cycles
// Assumes: done pulse one or four cycles after request
// Notes: read data toggles outside done
`timescale 1ns/1ps
module cbs_mem_model
  import cbs_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_n_i,
  input wire logic slow_i,
  input wire cbs_bus_s bus_i,
  output logic done_o,
  output logic [15:0] rdata_o
);
  logic [1:0] wait_r = 2'h0;
  always @(posedge clk_sys_i) begin
    if (!reset_n_i) begin
      wait_r <= 2'h0;
      done_o <= 1'b0;
      rdata_o <= 16'h0000;
    end else begin
      done_o <= 1'b0;
      rdata_o <= ~rdata_o;
      if (bus_i.valid && !done_o) begin
        if (wait_r >= {slow_i, slow_i}) begin
          done_o <= 1'b1;
          rdata_o <= bus_i.addr[15:0] ^ 16'h3c5a;
          wait_r <= 2'h0;
        end else begin
          wait_r <= wait_r + 2'h1;
        end
      end
    end
  end
endmodule

// ===== test/cbs_sequencer_tb_top.sv
// Purpose: directed checks of the bus-cycle sequencer
// Assumes: memory model answers every request
// Notes: completed bus cycles are logged
`timescale 1ns/1ps
module cbs_sequencer_tb_top
  import cbs_pkg::*;
;
  logic clk_sys_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic start = 1'b0;
  logic slow = 1'b0;
  cbs_cmd_s cmd = '0;
  logic mem_done;
  logic [15:0] mem_rdata;
  cbs_bus_s mem_bus;
  logic busy;
  logic done;
  logic [31:0] start_addr;
  logic [31:0] src_q;
  logic [31:0] dst_q;
  cbs_bus_s log_q[$];
  int mismatches = 0;
  int samples_checked = 0;

  initial begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  cbs_sequencer uut (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .start_i(start),
    .cmd_i(cmd), .mem_done_i(mem_done), .mem_rdata_i(mem_rdata),
    .mem_o(mem_bus), .busy_o(busy), .done_o(done),
    .start_addr_o(start_addr), .src_addr_reg_o(src_q),
    .dst_addr_reg_o(dst_q)
  );
  cbs_mem_model u_mem (
    .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .slow_i(slow),
    .bus_i(mem_bus), .done_o(mem_done), .rdata_o(mem_rdata)
  );
  always @(posedge clk_sys_i) begin
    if (mem_bus.valid && mem_done) begin
      log_q.push_back(mem_bus);
    end
  end
  // ---
  // helpers
  // ---
  function automatic logic [15:0] mw(input logic [31:0] a);
    return a[15:0] ^ 16'h3c5a;
  endfunction
  function automatic cbs_cmd_s mk(input cbs_op_e op, input logic [31:0] a,
      input logic [31:0] pc, input logic [15:0] n, input logic w);
    return '{op, a, pc, 32'h2000, 32'h3000, n, n[2:0], 16'h1234,
      16'h5678, 8'h85, w};
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic ent(input int i, input logic [2:0] wbl,
      input logic [31:0] a);
    cbs_bus_s e;
    e = (i < log_q.size()) ? log_q[i] : 'x;
    chk({e.write, e.byte_en, e.lock, e.addr}, {wbl, a});
  endtask
  task automatic run(input cbs_cmd_s c, input logic twice);
    int k;
    @(posedge clk_sys_i);
    cmd <= c;
    start <= 1'b1;
    log_q.delete();
    @(posedge clk_sys_i);
    start <= 1'b0;
    if (twice) begin
      repeat (3) @(posedge clk_sys_i);
      chk(busy, 1'b1);
      start <= 1'b1;
      @(posedge clk_sys_i);
      start <= 1'b0;
    end
    k = 0;
    do begin
      @(negedge clk_sys_i);
      k++;
    end while (done !== 1'b1 && k < 400);
    if (k >= 400) begin
      mismatches++;
      $display("unexpected at %0t: no done", $time);
    end
  endtask
  // ---
  // scenarios
  // ---
  task automatic t_reset();
    run(mk(CBS_OP_RESET, 32'h100, 0, 0, 0), 0);
    chk(log_q.size(), 3);
    ent(0, 3'b000, 32'h100);
    ent(1, 3'b000, 32'h102);
    ent(2, 3'b000, {mw(32'h100), mw(32'h102)});
    chk(start_addr, {mw(32'h100), mw(32'h102)});
  endtask
  task automatic t_irq(input logic w);
    int b;
    b = w ? 0 : 1;
    run(mk(CBS_OP_IRQ, 32'h400, 32'h0001_1000, 0, w), 0);
    chk(log_q.size(), 6 + b);
    if (!w) ent(0, 3'b000, 32'h0001_1002);
    ent(b, 3'b100, 32'h3fe);
    ent(b + 1, 3'b100, 32'h3fc);
    ent(b + 2, 3'b100, 32'h3fa);
    ent(b + 3, 3'b001, 32'h3000);
    ent(b + 4, 3'b000, 32'h3002);
    ent(b + 5, 3'b000, {mw(32'h3000), mw(32'h3002)});
    chk(log_q[b].wdata, 16'h1000);
    chk(log_q[b + 1].wdata, 16'h0001);
    chk(log_q[b + 2].wdata & 16'h00ff, 16'h0085);
    chk(start_addr, {mw(32'h3000), mw(32'h3002)});
  endtask
  task automatic t_ctrl();
    run(mk(CBS_OP_CTRL_STORE, 32'h500, 32'h1000, 0, 0), 0);
    chk(log_q.size(), 3);
    ent(0, 3'b000, 32'h1002);
    ent(1, 3'b000, 32'h1004);
    ent(2, 3'b100, 32'h4fe);
    chk(log_q[2].wdata, 16'h1234);
  endtask
  task automatic t_push(input int n);
    run(mk(CBS_OP_PUSH, 32'h800, 0, n[15:0], 0), 1);
    chk(log_q.size(), 2 * n);
    chk(log_q[0].wdata, 16'h5678);
    chk(log_q[1].wdata, 16'h1234);
    for (int i = 0; i < n; i++) begin
      ent(2 * i, 3'b101, 32'h7fc - 4 * i);
      ent(2 * i + 1, 3'b100, 32'h7fe - 4 * i);
    end
  endtask
  task automatic t_move(input int n);
    run(mk(CBS_OP_MOVE, 0, 0, n[15:0], 0), 0);
    chk(log_q.size(), 2 * n);
    for (int i = 0; i < n; i++) begin
      ent(2 * i, 3'b010, 32'h2000 + i);
      ent(2 * i + 1, 3'b110, 32'h3000 + i);
      chk(log_q[2 * i + 1].wdata & 16'h00ff,
          mw(32'h2000 + i) & 16'h00ff);
    end
    chk(src_q, 32'h2000 + n);
    chk(dst_q, 32'h3000 + n);
  endtask
  task automatic t_tas();
    // address from a recommended register
    run(mk(CBS_OP_TAS, 32'h601, 0, 0, 0), 0);
    chk(log_q.size(), 2);
    ent(0, 3'b011, 32'h601);
    ent(1, 3'b110, 32'h601);
    chk(log_q[1].wdata, 16'h00db);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    #100000;
    mismatches++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_irq(1'b0);
    t_irq(1'b1);
    @(posedge clk_sys_i);
    slow <= 1'b1;
    t_ctrl();
    for (int n = 2; n <= 4; n++) t_push(n);
    t_move(3);
    t_move(0);
    t_tas();
    end_of_test();
  end
endmodule
